// *** tb/awb_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module awb_ctrl_checker #(
    parameter longint TIMEOUT_CYCLES = awb_pkg::TIMEOUT_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic wb_auto_mode_we_i,
    input wire logic [1:0] wb_auto_mode_i,
    input wire logic per_channel_gain_mode_i,
    input wire logic gain_we_i,
    input wire logic [1:0] gain_sel_i,
    input wire logic [awb_pkg::GAIN_W-1:0] gain_data_i,
    input wire logic preset_load_i,
    input wire logic [1:0] preset_sel_i,
    input wire logic [1:0] wb_auto_mode_o,
    input wire logic [3:0] wb_result_status_o,
    input wire logic [awb_pkg::GAIN_W-1:0] gain_r_o,
    input wire logic [awb_pkg::GAIN_W-1:0] gain_g_o,
    input wire logic [awb_pkg::GAIN_W-1:0] gain_b_o
);
    // ----------------------------------------------------------------
    // Helper state: cycles spent running and the last running mode.
    // ----------------------------------------------------------------
    logic [31:0] run_cnt;
    logic [1:0] last_mode;
    logic busy;
    assign busy = wb_result_status_o == awb_pkg::RES_PROCESSING;
    default clocking dcb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    always_ff @(posedge ref_clk_i) begin
        if (srst_i || !busy) begin
            run_cnt <= 32'h0;
        end else begin
            run_cnt <= run_cnt + 32'h1;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            last_mode <= awb_pkg::MODE_OFF;
        end else if (wb_auto_mode_o != awb_pkg::MODE_OFF) begin
            last_mode <= wb_auto_mode_o;
        end
    end
    // ----------------------------------------------------------------
    // Assertions and cover points.
    // ----------------------------------------------------------------
    start_take_a: assert property (wb_auto_mode_we_i && !per_channel_gain_mode_i
        && wb_auto_mode_o == awb_pkg::MODE_OFF && (wb_auto_mode_i == awb_pkg::MODE_ONCE
        || wb_auto_mode_i == awb_pkg::MODE_ONCE_BE) |=> wb_auto_mode_o == $past(wb_auto_mode_i)
        && busy) else $error("Start request not taken.");
    busy_mode_a: assert property ((wb_auto_mode_o != awb_pkg::MODE_OFF) == busy)
        else $error("Mode and processing status disagree.");
    abort_idle_a: assert property (wb_auto_mode_we_i && wb_auto_mode_i == awb_pkg::MODE_OFF
        |=> wb_result_status_o == awb_pkg::RES_IDLE || wb_result_status_o >= 4'h2)
        else $error("Abort left status processing.");
    per_chan_off_a: assert property (per_channel_gain_mode_i |=> wb_auto_mode_o == 2'h0)
        else $error("Per-channel mode did not force auto off.");
    off_hold_a: assert property (wb_auto_mode_o == 2'h0 && !gain_we_i && !preset_load_i
        |=> $stable(gain_r_o) && $stable(gain_g_o) && $stable(gain_b_o))
        else $error("Gain changed while auto mode off.");
    man_write_a: assert property (gain_we_i && gain_sel_i == awb_pkg::CH_RED
        |=> gain_r_o == $past(gain_data_i)) else $error("Manual red gain not applied.");
    preset_low_a: assert property (preset_load_i && preset_sel_i == awb_pkg::PRESET_LOW
        && !per_channel_gain_mode_i && !gain_we_i && wb_auto_mode_o == 2'h0
        |=> gain_r_o == awb_pkg::PRESET_LOW_R && gain_b_o == awb_pkg::PRESET_LOW_B)
        else $error("Low preset gains wrong.");
    preset_block_a: assert property (preset_load_i && per_channel_gain_mode_i
        && !gain_we_i && wb_auto_mode_o == 2'h0 |=> $stable(gain_r_o) && $stable(gain_b_o))
        else $error("Preset taken in per-channel mode.");
    time_limit_a: assert property (busy |-> run_cnt <= TIMEOUT_CYCLES + 1)
        else $error("Adjustment ran past the timeout.");
    time_early_a: assert property ((wb_result_status_o == awb_pkg::RES_ERR_TIMEOUT
        || wb_result_status_o == awb_pkg::RES_SUCCEEDED_BE) && $past(busy)
        |-> $past(run_cnt) + 3 >= TIMEOUT_CYCLES) else $error("Timeout reported early.");
    err_once_a: assert property (wb_result_status_o >= awb_pkg::RES_ERR_G_BRIGHT
        |-> last_mode == awb_pkg::MODE_ONCE) else $error("Error code outside windowed mode.");
    be_only_a: assert property (wb_result_status_o == awb_pkg::RES_SUCCEEDED_BE
        |-> last_mode == awb_pkg::MODE_ONCE_BE) else $error("Best-effort code in windowed mode.");
    ok_c: cover property (wb_result_status_o == awb_pkg::RES_SUCCEEDED);
    be_c: cover property (wb_result_status_o == awb_pkg::RES_SUCCEEDED_BE);
    tmo_c: cover property (wb_result_status_o == awb_pkg::RES_ERR_TIMEOUT);
endmodule
bind awb_ctrl awb_ctrl_checker #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_auto_mode_we_i(wb_auto_mode_we_i),
    .wb_auto_mode_i(wb_auto_mode_i), .per_channel_gain_mode_i(per_channel_gain_mode_i),
    .gain_we_i(gain_we_i), .gain_sel_i(gain_sel_i), .gain_data_i(gain_data_i),
    .preset_load_i(preset_load_i), .preset_sel_i(preset_sel_i),
    .wb_auto_mode_o(wb_auto_mode_o), .wb_result_status_o(wb_result_status_o),
    .gain_r_o(gain_r_o), .gain_g_o(gain_g_o), .gain_b_o(gain_b_o));
`default_nettype wire

// *** tb/awb_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module awb_ctrl_test;
    localparam longint TMO = 10000;
    typedef struct {logic k; logic [1:0] s; logic [11:0] d, r, g, b;} awb_row_t;
    logic ref_clk_i, srst_i, pv, ls, fe, mwe, pcm, gwe, pld;
    logic [7:0] pr, pg, pb, tgt;
    logic [1:0] mode, gsel, psel, mode_o;
    logic [11:0] aw, ax, gdat, gr, gg, gb;
    logic [3:0] st;
    int mismatches, comparisons;
    awb_row_t rows [9] = '{'{0, 0, 0, 12'h480, 12'h400, 12'h3A0},
        '{0, 1, 0, 12'h400, 12'h400, 12'h400}, '{0, 2, 0, 12'h3A0, 12'h400, 12'h480},
        '{0, 3, 0, 12'h3A0, 12'h400, 12'h480}, '{1, 0, 12'h123, 12'h123, 12'h400, 12'h480},
        '{1, 1, 12'h456, 12'h123, 12'h456, 12'h480}, '{1, 2, 12'h789, 12'h123, 12'h456, 12'h789},
        '{1, 3, 12'hABC, 12'h123, 12'h456, 12'h789}, '{0, 1, 0, 12'h400, 12'h400, 12'h400}};
    awb_ctrl #(.TIMEOUT_CYCLES(TMO)) uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
        .pix_valid_i(pv), .line_start_i(ls), .frame_end_i(fe), .pix_r_i(pr), .pix_g_i(pg),
        .pix_b_i(pb), .wb_auto_mode_we_i(mwe), .wb_auto_mode_i(mode), .wb_area_width_i(aw),
        .wb_area_x_start_i(ax), .target_level_i(tgt), .per_channel_gain_mode_i(pcm),
        .gain_we_i(gwe), .gain_sel_i(gsel), .gain_data_i(gdat), .preset_load_i(pld),
        .preset_sel_i(psel), .wb_auto_mode_o(mode_o), .wb_result_status_o(st),
        .gain_r_o(gr), .gain_g_o(gg), .gain_b_o(gb));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic apply(input logic k, input logic [1:0] s, input logic [11:0] d);
        @(posedge ref_clk_i);
        pld <= !k;
        psel <= s;
        gwe <= k;
        gsel <= s;
        gdat <= d;
        @(posedge ref_clk_i);
        pld <= 1'b0;
        gwe <= 1'b0;
        @(negedge ref_clk_i);
    endtask
    task automatic frame(input logic [7:0] r, g, b, rx);
        for (int x = 0; x < 6; x++) begin
            @(posedge ref_clk_i);
            pv <= 1'b1;
            ls <= x == 0;
            pg <= g;
            pb <= b;
            pr <= (x == 2 || x == 3) ? r : rx;
        end
        @(posedge ref_clk_i);
        pv <= 1'b0;
        ls <= 1'b0;
        fe <= 1'b1;
        @(posedge ref_clk_i);
        fe <= 1'b0;
        @(negedge ref_clk_i);
    endtask
    task automatic wr_mode(input logic [1:0] m);
        @(posedge ref_clk_i);
        mwe <= 1'b1;
        mode <= m;
        @(posedge ref_clk_i);
        mwe <= 1'b0;
        @(negedge ref_clk_i);
    endtask
    task automatic run(input logic [1:0] m, input logic [7:0] r, g, b, rx, t,
            input logic fr, input logic [3:0] exp);
        int n;
        apply(1'b0, awb_pkg::PRESET_MID, 12'h000);
        tgt <= t;
        wr_mode(m);
        chk(mode_o, m);
        chk(st, awb_pkg::RES_PROCESSING);
        n = 0;
        while (st === awb_pkg::RES_PROCESSING && n < 1400) begin
            if (fr) frame(r, g, b, rx);
            else repeat (9) @(negedge ref_clk_i);
            n++;
        end
        chk(st, exp);
        chk(mode_o, awb_pkg::MODE_OFF);
    endtask
    // ----------------------------------------------------------------
    // Main sequence and watchdog.
    // ----------------------------------------------------------------
    initial begin
        {srst_i, pv, ls, fe, mwe, pcm, gwe, pld} = 8'h80;
        {pr, pg, pb, tgt, mode, gsel, psel, ax, gdat} = '0;
        aw = 12'hFFF;
        repeat (12) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        @(negedge ref_clk_i);
        chk({st, mode_o}, 16'h0);
        chk({gr, gb}, 16'h0400);
        foreach (rows[i]) begin
            apply(rows[i].k, rows[i].s, rows[i].d);
            chk(gr, rows[i].r);
            chk(gg, rows[i].g);
            chk(gb, rows[i].b);
        end
        frame(8'h20, 8'h80, 8'h80, 8'h20);
        chk(gr, 12'h400);
        ax <= 12'h002;
        aw <= 12'h002;
        run(1, 8'h80, 8'h80, 8'h80, 8'h00, 8'h80, 1, awb_pkg::RES_SUCCEEDED);
        run(2, 8'h80, 8'h80, 8'h80, 8'h00, 8'h80, 1, awb_pkg::RES_SUCCEEDED_BE);
        ax <= 12'h000;
        aw <= 12'hFFF;
        run(2, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 1, awb_pkg::RES_SUCCEEDED);
        run(1, 8'h80, 8'h80, 8'h80, 8'h80, 8'h90, 1, awb_pkg::RES_ERR_TGT_HIGH);
        run(1, 8'h80, 8'h80, 8'h80, 8'h80, 8'h40, 1, awb_pkg::RES_ERR_TGT_LOW);
        run(1, 8'h40, 8'h80, 8'h80, 8'h40, 8'h80, 1, awb_pkg::RES_ERR_G_BRIGHT);
        run(1, 8'hC0, 8'h80, 8'h80, 8'hC0, 8'h80, 1, awb_pkg::RES_ERR_G_DARK);
        run(1, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 0, awb_pkg::RES_ERR_TIMEOUT);
        wr_mode(awb_pkg::MODE_ONCE);
        wr_mode(awb_pkg::MODE_ONCE_BE);
        chk(mode_o, awb_pkg::MODE_ONCE);
        wr_mode(awb_pkg::MODE_OFF);
        chk({st, mode_o}, 16'h0);
        wr_mode(awb_pkg::MODE_ONCE);
        pcm <= 1'b1;
        @(negedge ref_clk_i);
        chk({st, mode_o}, 16'h0);
        wr_mode(awb_pkg::MODE_ONCE);
        chk(mode_o, awb_pkg::MODE_OFF);
        apply(1'b1, awb_pkg::CH_RED, 12'h123);
        apply(1'b0, awb_pkg::PRESET_LOW, 12'h000);
        chk(gr, 12'h123);
        pcm <= 1'b0;
        final_report;
    end
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        mismatches++;
        final_report;
    end
endmodule
`default_nettype wire

// *** verilog/awb_ctrl.sv ***
// Summary of operation
// - Windowed mode measures region, aborts if impossible.
// - Best-effort mode measures whole image, nears target.
// - Area settings used only in windowed mode.
// - Per-channel gain mode forces auto off.
// - Auto off: gains change only by writes and preset loads.
// - Finished adjustment reports success, mode returns off.
// - Windowed retries end at timeout with failure.
// - Best-effort adjusts until convergence or timeout, then reports.
// - Status idle when stopped, processing while running.
// - Green too bright versus red/blue: error 1.
// - Green too dark versus red/blue: error 2.
// - Windowed timeout reports error 3.
// - Target too high error 4, low 5.
// - Best-effort limited balance reports best-effort success.
// - Best-effort normal completion reports success, mode off.
// - Presets 5000K/6500K/7500K need per-channel mode off.
`timescale 1ns/1ps
`default_nettype none
module awb_ctrl #(
    parameter longint TIMEOUT_CYCLES = awb_pkg::TIMEOUT_CYCLES
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic pix_valid_i,
    input wire logic line_start_i,
    input wire logic frame_end_i,
    input wire logic [awb_pkg::PIX_W-1:0] pix_r_i,
    input wire logic [awb_pkg::PIX_W-1:0] pix_g_i,
    input wire logic [awb_pkg::PIX_W-1:0] pix_b_i,
    input wire logic wb_auto_mode_we_i,
    input wire logic [1:0] wb_auto_mode_i,
    input wire logic [awb_pkg::X_W-1:0] wb_area_width_i,
    input wire logic [awb_pkg::X_W-1:0] wb_area_x_start_i,
    input wire logic [awb_pkg::PIX_W-1:0] target_level_i,
    input wire logic per_channel_gain_mode_i,
    input wire logic gain_we_i,
    input wire logic [1:0] gain_sel_i,
    input wire logic [awb_pkg::GAIN_W-1:0] gain_data_i,
    input wire logic preset_load_i,
    input wire logic [1:0] preset_sel_i,
    output logic [1:0] wb_auto_mode_o,
    output logic [3:0] wb_result_status_o,
    output logic [awb_pkg::GAIN_W-1:0] gain_r_o,
    output logic [awb_pkg::GAIN_W-1:0] gain_g_o,
    output logic [awb_pkg::GAIN_W-1:0] gain_b_o
);
    localparam int SW = awb_pkg::SUM_W;
    localparam logic [awb_pkg::TMR_W-1:0] TMO_LAST = awb_pkg::TMR_W'(TIMEOUT_CYCLES - 1);

    typedef enum logic [0:0] {AWB_IDLE, AWB_RUN} awb_state_t;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    awb_state_t state;
    logic be_mode;
    logic be_limited;
    logic [awb_pkg::TMR_W-1:0] timer;
    logic start_req;
    logic abort_req;
    logic timed_out;
    logic [SW-1:0] tgt_sum;
    logic [SW-1:0] tol_g;
    logic [SW-1:0] tol_t;
    logic r_low;
    logic r_high;
    logic b_low;
    logic b_high;
    logic g_low;
    logic g_high;
    logic converged;
    logic err_g_bright;
    logic err_g_dark;
    logic err_t_high;
    logic err_t_low;
    logic any_limit;
    logic stat_run;
    logic [2:0] man_we;
    logic preset_we;
    logic [awb_pkg::GAIN_W-1:0] preset_r;
    logic [awb_pkg::GAIN_W-1:0] preset_b;
    logic r_max;
    logic r_min;
    logic g_max;
    logic g_min;
    logic b_max;
    logic b_min;

    awb_stat_if st ();

    // ----------------------------------------------------------------
    // Statistics
    // ----------------------------------------------------------------
    assign st.win_en = !be_mode;
    assign st.x_start = wb_area_x_start_i;
    assign st.width = wb_area_width_i;

    awb_stat_acc u_acc (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .pix_valid_i(pix_valid_i),
        .line_start_i(line_start_i),
        .frame_end_i(frame_end_i),
        .pix_r_i(pix_r_i),
        .pix_g_i(pix_g_i),
        .pix_b_i(pix_b_i),
        .st(st)
    );

    // ----------------------------------------------------------------
    // Frame evaluation
    // ----------------------------------------------------------------
    assign tgt_sum = SW'(st.count) * SW'(target_level_i);
    assign tol_g = st.sum_g >> awb_pkg::TOL_SHIFT;
    assign tol_t = tgt_sum >> awb_pkg::TOL_SHIFT;
    assign r_low = st.sum_r + tol_g < st.sum_g;
    assign r_high = st.sum_r > st.sum_g + tol_g;
    assign b_low = st.sum_b + tol_g < st.sum_g;
    assign b_high = st.sum_b > st.sum_g + tol_g;
    assign g_low = st.sum_g + tol_t < tgt_sum;
    assign g_high = st.sum_g > tgt_sum + tol_t;
    assign converged = !(r_low || r_high || b_low || b_high || g_low || g_high);
    assign err_g_bright = (r_low && r_max) || (b_low && b_max);
    assign err_g_dark = (r_high && r_min) || (b_high && b_min);
    assign err_t_high = g_low && g_max;
    assign err_t_low = g_high && g_min;
    assign any_limit = err_g_bright || err_g_dark || err_t_high || err_t_low;
    assign stat_run = (state == AWB_RUN) && st.stat_valid && !abort_req;

    // ----------------------------------------------------------------
    // Start, abort and timeout
    // ----------------------------------------------------------------
    assign start_req = wb_auto_mode_we_i && !per_channel_gain_mode_i && (state == AWB_IDLE)
        && (wb_auto_mode_i == awb_pkg::MODE_ONCE || wb_auto_mode_i == awb_pkg::MODE_ONCE_BE);
    assign abort_req = per_channel_gain_mode_i
        || (wb_auto_mode_we_i && wb_auto_mode_i == awb_pkg::MODE_OFF);
    assign timed_out = (state == AWB_RUN) && (timer == TMO_LAST);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            state <= AWB_IDLE;
            wb_auto_mode_o <= awb_pkg::MODE_OFF;
        end else if (per_channel_gain_mode_i) begin
            state <= AWB_IDLE;
            wb_auto_mode_o <= awb_pkg::MODE_OFF;
        end else if (start_req) begin
            state <= AWB_RUN;
            wb_auto_mode_o <= wb_auto_mode_i;
        end else if (state == AWB_RUN) begin
            if (abort_req || timed_out || (stat_run && (converged
                || (!be_mode && any_limit)))) begin
                state <= AWB_IDLE;
                wb_auto_mode_o <= awb_pkg::MODE_OFF;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            be_mode <= 1'b0;
        end else if (start_req) begin
            be_mode <= (wb_auto_mode_i == awb_pkg::MODE_ONCE_BE);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || state == AWB_IDLE) begin
            timer <= '0;
        end else if (!timed_out) begin
            timer <= timer + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || start_req) begin
            be_limited <= 1'b0;
        end else if (stat_run && be_mode && (any_limit || !converged)) begin
            be_limited <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Result status
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wb_result_status_o <= awb_pkg::RES_IDLE;
        end else if (start_req) begin
            wb_result_status_o <= awb_pkg::RES_PROCESSING;
        end else if (state == AWB_RUN) begin
            if (abort_req) begin
                wb_result_status_o <= awb_pkg::RES_IDLE;
            end else if (stat_run && converged) begin
                wb_result_status_o <= awb_pkg::RES_SUCCEEDED;
            end else if (stat_run && !be_mode && err_t_high) begin
                wb_result_status_o <= awb_pkg::RES_ERR_TGT_HIGH;
            end else if (stat_run && !be_mode && err_t_low) begin
                wb_result_status_o <= awb_pkg::RES_ERR_TGT_LOW;
            end else if (stat_run && !be_mode && err_g_bright) begin
                wb_result_status_o <= awb_pkg::RES_ERR_G_BRIGHT;
            end else if (stat_run && !be_mode && err_g_dark) begin
                wb_result_status_o <= awb_pkg::RES_ERR_G_DARK;
            end else if (timed_out && be_mode) begin
                wb_result_status_o <= awb_pkg::RES_SUCCEEDED_BE;
            end else if (timed_out) begin
                wb_result_status_o <= awb_pkg::RES_ERR_TIMEOUT;
            end
        end
    end

    // ----------------------------------------------------------------
    // Gain channels
    // ----------------------------------------------------------------
    assign man_we[0] = gain_we_i && gain_sel_i == awb_pkg::CH_RED;
    assign man_we[1] = gain_we_i && gain_sel_i == awb_pkg::CH_GREEN;
    assign man_we[2] = gain_we_i && gain_sel_i == awb_pkg::CH_BLUE;
    assign preset_we = preset_load_i && !per_channel_gain_mode_i
        && preset_sel_i != 2'h3 && state == AWB_IDLE;

    always_comb begin
        preset_r = awb_pkg::PRESET_MID_R;
        preset_b = awb_pkg::PRESET_MID_B;
        unique case (preset_sel_i)
            awb_pkg::PRESET_LOW: begin
                preset_r = awb_pkg::PRESET_LOW_R;
                preset_b = awb_pkg::PRESET_LOW_B;
            end
            awb_pkg::PRESET_HIGH: begin
                preset_r = awb_pkg::PRESET_HIGH_R;
                preset_b = awb_pkg::PRESET_HIGH_B;
            end
            default: begin
                preset_r = awb_pkg::PRESET_MID_R;
                preset_b = awb_pkg::PRESET_MID_B;
            end
        endcase
    end

    // Automatic steps happen only on a frame result while running.
    awb_gain_chan u_gain_r (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .man_we_i(man_we[0]),
        .man_data_i(gain_data_i),
        .preset_we_i(preset_we),
        .preset_data_i(preset_r),
        .step_up_i(stat_run && r_low),
        .step_dn_i(stat_run && r_high),
        .gain_o(gain_r_o),
        .at_max_o(r_max),
        .at_min_o(r_min)
    );

    awb_gain_chan u_gain_g (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .man_we_i(man_we[1]),
        .man_data_i(gain_data_i),
        .preset_we_i(preset_we),
        .preset_data_i(awb_pkg::GAIN_RESET),
        .step_up_i(stat_run && g_low),
        .step_dn_i(stat_run && g_high),
        .gain_o(gain_g_o),
        .at_max_o(g_max),
        .at_min_o(g_min)
    );

    awb_gain_chan u_gain_b (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .man_we_i(man_we[2]),
        .man_data_i(gain_data_i),
        .preset_we_i(preset_we),
        .preset_data_i(preset_b),
        .step_up_i(stat_run && b_low),
        .step_dn_i(stat_run && b_high),
        .gain_o(gain_b_o),
        .at_max_o(b_max),
        .at_min_o(b_min)
    );
endmodule
`default_nettype wire

// *** verilog/awb_gain_chan.sv ***
`timescale 1ns/1ps
`default_nettype none
module awb_gain_chan (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic man_we_i,
    input wire logic [awb_pkg::GAIN_W-1:0] man_data_i,
    input wire logic preset_we_i,
    input wire logic [awb_pkg::GAIN_W-1:0] preset_data_i,
    input wire logic step_up_i,
    input wire logic step_dn_i,
    output logic [awb_pkg::GAIN_W-1:0] gain_o,
    output logic at_max_o,
    output logic at_min_o
);
    assign at_max_o = gain_o > (awb_pkg::GAIN_MAX - awb_pkg::GAIN_STEP);
    assign at_min_o = gain_o < (awb_pkg::GAIN_MIN + awb_pkg::GAIN_STEP);

    // Manual writes win over presets, presets over automatic steps.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            gain_o <= awb_pkg::GAIN_RESET;
        end else if (man_we_i) begin
            gain_o <= man_data_i;
        end else if (preset_we_i) begin
            gain_o <= preset_data_i;
        end else if (step_up_i && !at_max_o) begin
            gain_o <= gain_o + awb_pkg::GAIN_STEP;
        end else if (step_dn_i && !at_min_o) begin
            gain_o <= gain_o - awb_pkg::GAIN_STEP;
        end
    end
endmodule
`default_nettype wire

// *** verilog/awb_pkg.sv ***
package awb_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int PIX_W = 8;
    localparam int GAIN_W = 12;
    localparam int SUM_W = 40;
    localparam int CNT_W = 24;
    localparam int X_W = 12;
    localparam int TMR_W = 34;

    // ----------------------------------------------------------------
    // Auto mode codes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_ONCE = 2'h1;
    localparam logic [1:0] MODE_ONCE_BE = 2'h2;

    // ----------------------------------------------------------------
    // Result status codes
    // ----------------------------------------------------------------
    localparam logic [3:0] RES_IDLE = 4'h0;
    localparam logic [3:0] RES_PROCESSING = 4'h1;
    localparam logic [3:0] RES_SUCCEEDED = 4'h2;
    localparam logic [3:0] RES_SUCCEEDED_BE = 4'h3;
    localparam logic [3:0] RES_ERR_G_BRIGHT = 4'h4;
    localparam logic [3:0] RES_ERR_G_DARK = 4'h5;
    localparam logic [3:0] RES_ERR_TIMEOUT = 4'h6;
    localparam logic [3:0] RES_ERR_TGT_HIGH = 4'h7;
    localparam logic [3:0] RES_ERR_TGT_LOW = 4'h8;

    // ----------------------------------------------------------------
    // Gain channel select and colour temperature presets
    // ----------------------------------------------------------------
    localparam logic [1:0] CH_RED = 2'h0;
    localparam logic [1:0] CH_GREEN = 2'h1;
    localparam logic [1:0] CH_BLUE = 2'h2;
    localparam logic [1:0] PRESET_LOW = 2'h0;
    localparam logic [1:0] PRESET_MID = 2'h1;
    localparam logic [1:0] PRESET_HIGH = 2'h2;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 12'h400;
    localparam logic [GAIN_W-1:0] GAIN_MAX = 12'hFFF;
    localparam logic [GAIN_W-1:0] GAIN_MIN = 12'h040;
    localparam logic [GAIN_W-1:0] GAIN_STEP = 12'h004;
    localparam logic [GAIN_W-1:0] PRESET_LOW_R = 12'h480;
    localparam logic [GAIN_W-1:0] PRESET_LOW_B = 12'h3A0;
    localparam logic [GAIN_W-1:0] PRESET_MID_R = 12'h400;
    localparam logic [GAIN_W-1:0] PRESET_MID_B = 12'h400;
    localparam logic [GAIN_W-1:0] PRESET_HIGH_R = 12'h3A0;
    localparam logic [GAIN_W-1:0] PRESET_HIGH_B = 12'h480;

    // ----------------------------------------------------------------
    // Target level limits and convergence tolerance
    // ----------------------------------------------------------------
    localparam logic [PIX_W-1:0] TARGET_MAX = 8'hF0;
    localparam logic [PIX_W-1:0] TARGET_MIN = 8'h10;
    localparam int TOL_SHIFT = 5;

    // ----------------------------------------------------------------
    // Retry timeout
    // ----------------------------------------------------------------
    localparam longint TIMEOUT_S = 10;
    localparam longint CLK_HZ = 100000000;
    localparam longint TIMEOUT_CYCLES = TIMEOUT_S * CLK_HZ;

endpackage

// *** verilog/awb_stat_acc.sv ***
`timescale 1ns/1ps
`default_nettype none
module awb_stat_acc (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic pix_valid_i,
    input wire logic line_start_i,
    input wire logic frame_end_i,
    input wire logic [awb_pkg::PIX_W-1:0] pix_r_i,
    input wire logic [awb_pkg::PIX_W-1:0] pix_g_i,
    input wire logic [awb_pkg::PIX_W-1:0] pix_b_i,
    awb_stat_if.acc st
);
    logic [awb_pkg::X_W-1:0] x_pos;
    logic [awb_pkg::X_W-1:0] x_cur;
    logic [awb_pkg::X_W:0] x_end;
    logic in_area;
    logic [awb_pkg::SUM_W-1:0] acc_r;
    logic [awb_pkg::SUM_W-1:0] acc_g;
    logic [awb_pkg::SUM_W-1:0] acc_b;
    logic [awb_pkg::CNT_W-1:0] acc_n;

    assign x_cur = line_start_i ? '0 : x_pos;
    assign x_end = {1'b0, st.x_start} + {1'b0, st.width};
    assign in_area = !st.win_en || (x_cur >= st.x_start && {1'b0, x_cur} < x_end);

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            x_pos <= '0;
        end else if (pix_valid_i) begin
            x_pos <= x_cur + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i || frame_end_i) begin
            acc_r <= '0;
            acc_g <= '0;
            acc_b <= '0;
            acc_n <= '0;
        end else if (pix_valid_i && in_area) begin
            acc_r <= acc_r + awb_pkg::SUM_W'(pix_r_i);
            acc_g <= acc_g + awb_pkg::SUM_W'(pix_g_i);
            acc_b <= acc_b + awb_pkg::SUM_W'(pix_b_i);
            acc_n <= acc_n + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            st.stat_valid <= 1'b0;
            st.sum_r <= '0;
            st.sum_g <= '0;
            st.sum_b <= '0;
            st.count <= '0;
        end else begin
            st.stat_valid <= frame_end_i && (acc_n != '0);
            if (frame_end_i) begin
                st.sum_r <= acc_r;
                st.sum_g <= acc_g;
                st.sum_b <= acc_b;
                st.count <= acc_n;
            end
        end
    end
endmodule
`default_nettype wire

// *** verilog/awb_stat_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface awb_stat_if;
    logic win_en;
    logic [awb_pkg::X_W-1:0] x_start;
    logic [awb_pkg::X_W-1:0] width;
    logic stat_valid;
    logic [awb_pkg::SUM_W-1:0] sum_r;
    logic [awb_pkg::SUM_W-1:0] sum_g;
    logic [awb_pkg::SUM_W-1:0] sum_b;
    logic [awb_pkg::CNT_W-1:0] count;

    modport acc (input win_en, x_start, width, output stat_valid, sum_r, sum_g, sum_b, count);
    modport ctl (output win_en, x_start, width, input stat_valid, sum_r, sum_g, sum_b, count);
endinterface
`default_nettype wire
